/* event_trigger_hold_control.sv */
// Event trigger, hold and gate-delay controller for a panel meter
// Function
// R01 - Normal mode: gate input only lights the indicator; measuring never stops for it.
// R02 - Hold freezes the display at its value at hold onset; gate, startup ignored.
// R03 - Normal mode measures through scaling errors; held value shows once error clears.
// R04 - Sampling hold takes one measurement at the gate assertion edge and keeps it.
// R05 - Sampling hold skips the edge measurement during a scaling or burnout error.
// R06 - Peak, valley, peak-to-peak: error stops measuring and voids that gate period.
// R07 - Reset clears data, stops measuring; outside normal mode gate is ignored.
// R08 - Peak hold tracks maximum while gated and shows it at gate release.
// R09 - Valley hold tracks minimum while gated and shows it at gate release.
// R10 - Peak-to-peak tracks both and shows maximum minus minimum at gate release.
// R11 - Analog level follows the display and is zero with no measured data.
// R12 - Hold input is disregarded while reset is asserted.
// R13 - Outside normal mode a one-shot pulse marks every measurement instant.
// R14 - Reset clears stored maximum and minimum even under panel lockout.
// R15 - Panel requests for maximum or minimum are refused with no measured data.
// R16 - Sampling hold updates stored maximum and minimum at each gate assertion edge.
// R17 - Gated modes offer maximum and minimum gathered while the gate was on.
// R18 - Internal gate follows physical gate after programmed ON or OFF delay.
// R19 - A new gate assertion during a pending delay cancels the earlier event.
// R20 - The source keeps the gate on longer than the ON delay.
// R21 - Normal mode bypasses both delays; sampling hold bypasses the OFF delay.
// R22 - Startup inhibit during a delay pauses its count for the startup period.
// R23 - Normal mode: startup inhibit suspends measuring for the startup period.
// R24 - Gate, startup inhibit, hold and reset inputs are active low.
// R25 - Every mode suppresses measuring for the startup period from inhibit onset.
// R26 - Five trigger modes, normal selected after reset.
// R27 - Delays and startup timer count 0.1 second ticks from the system clock.
`timescale 1ns/1ps
module event_trigger_hold_control #(
	parameter int W = trig_pkg::DATA_W,
	parameter int TICK_CYCLES = trig_pkg::TICK_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic gate_n,
	input wire logic hold_n,
	input wire logic trig_reset_n,
	input wire logic startup_inhibit_input_n,
	input wire logic sample_valid,
	input wire logic signed [W-1:0] sample_value,
	input wire logic scale_error,
	output logic signed [W-1:0] display_value,
	output logic display_error,
	output logic signed [W-1:0] analog_level,
	output logic signed [W-1:0] panel_value,
	output logic gate_active_indicator,
	output logic one_shot,
	output logic measuring
);
	localparam int TW = $clog2(TICK_CYCLES + 1);

	typedef struct packed {
		logic g1;
		logic g2;
		logic h1;
		logic h2;
		logic r1;
		logic r2;
		logic s1;
		logic s2;
		logic st_d;
		logic hold_d;
		logic gate_eff;
		logic gate_d;
		trig_pkg::dly_t dly;
		logic [13:0] dcnt;
		logic gate_int;
		logic gate_int_d;
		logic [TW-1:0] tcnt;
		logic [9:0] stcnt;
		logic signed [W-1:0] live;
		logic signed [W-1:0] res;
		logic signed [W-1:0] held;
		logic has_data;
		logic signed [W-1:0] mx;
		logic signed [W-1:0] mn;
		logic mm_valid;
		logic signed [W-1:0] pmx;
		logic signed [W-1:0] pmn;
		logic pseen;
		logic perr;
		logic pulse;
		logic signed [W-1:0] disp;
		logic derr;
		logic signed [W-1:0] analog;
		logic signed [W-1:0] panel;
		logic refused;
		logic ind;
		logic meas;
	} state_t;
	// Synchronisers idle at the deasserted (high) level
	localparam state_t ST_RESET = '{g1: 1'b1, g2: 1'b1, h1: 1'b1, h2: 1'b1, r1: 1'b1, r2: 1'b1,
		s1: 1'b1, s2: 1'b1, st_d: 1'b0, dly: trig_pkg::DLY_IDLE, default: '0};

	state_t s;
	state_t next_s;
	cfg_if #(.W(W)) cfg ();

	axil_regs regs (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.cfg(cfg)
	);

	logic gate_on;
	logic hold_on;
	logic rst_on;
	logic st_on;
	logic normal;
	logic tick;
	logic busy;
	logic allow;
	logic rise;
	logic grise;
	logic gfall;
	logic [13:0] on_len;
	logic [13:0] off_len;
	logic signed [W-1:0] dv;

	assign gate_on = !s.g2; // R24
	assign rst_on = !s.r2; // R24
	assign st_on = !s.s2; // R24
	assign hold_on = !s.h2 && !rst_on; // R24 R12
	assign normal = cfg.mode == trig_pkg::MODE_NORMAL;
	assign tick = s.tcnt == TW'(TICK_CYCLES - 1); // R27
	assign busy = s.stcnt != 10'h000;
	assign allow = !rst_on && !busy; // R07 R25 R23
	assign rise = s.gate_eff && !s.gate_d;
	assign grise = s.gate_int && !s.gate_int_d;
	assign gfall = !s.gate_int && s.gate_int_d;
	assign on_len = normal ? 14'h0000 : cfg.on_ticks; // R21
	assign off_len = (normal || cfg.mode == trig_pkg::MODE_SAMPLE) ? 14'h0000 : cfg.off_ticks; // R21

	assign cfg.status = {scale_error, rst_on, s.refused, busy, hold_on, s.gate_int, s.has_data};
	assign cfg.display = s.disp;
	assign cfg.max_val = s.mx;
	assign cfg.min_val = s.mn;
	assign display_value = s.disp;
	assign display_error = s.derr;
	assign analog_level = s.analog;
	assign panel_value = s.panel;
	assign gate_active_indicator = s.ind;
	assign one_shot = s.pulse;
	assign measuring = s.meas;

	always_comb begin
		next_s = s;
		next_s.g1 = gate_n;
		next_s.g2 = s.g1;
		next_s.h1 = hold_n;
		next_s.h2 = s.h1;
		next_s.r1 = trig_reset_n;
		next_s.r2 = s.r1;
		next_s.s1 = startup_inhibit_input_n;
		next_s.s2 = s.s1;
		next_s.pulse = 1'b0;
		dv = '0;

		next_s.tcnt = tick ? '0 : TW'(s.tcnt + 1'b1); // R27

		// Startup timer starts on the inhibit assertion edge; hold masks it
		next_s.st_d = st_on;
		if (st_on && !s.st_d && !hold_on) begin
			next_s.stcnt = cfg.st_ticks; // R25 R23
		end else if (tick && busy) begin
			next_s.stcnt = 10'(s.stcnt - 1'b1);
		end

		// Hold keeps the gate level seen at its onset
		if (hold_on) begin
			next_s.gate_eff = s.gate_eff; // R02
		end else if (rst_on && !normal) begin
			next_s.gate_eff = 1'b0; // R07
		end else begin
			next_s.gate_eff = gate_on;
		end
		next_s.gate_d = s.gate_eff;

		case (s.dly)
			trig_pkg::DLY_IDLE: begin
				if (s.gate_eff && !s.gate_int) begin
					if (on_len == 14'h0000) begin
						next_s.gate_int = 1'b1; // R21
					end else begin
						next_s.dly = trig_pkg::DLY_ON; // R18
						next_s.dcnt = on_len;
					end
				end else if (!s.gate_eff && s.gate_int) begin
					if (off_len == 14'h0000) begin
						next_s.gate_int = 1'b0; // R21
					end else begin
						next_s.dly = trig_pkg::DLY_OFF; // R18
						next_s.dcnt = off_len;
					end
				end
			end
			trig_pkg::DLY_ON: begin
				if (rise) begin
					next_s.dcnt = on_len; // R19
				end else if (tick && !busy) begin // R22
					if (s.dcnt <= 14'h0001) begin
						next_s.gate_int = 1'b1; // R18
						next_s.dly = trig_pkg::DLY_IDLE;
					end else begin
						next_s.dcnt = 14'(s.dcnt - 1'b1);
					end
				end
			end
			trig_pkg::DLY_OFF: begin
				// A fresh assertion drops the pending release and the period continues
				if (rise) begin
					next_s.dly = trig_pkg::DLY_IDLE; // R19
				end else if (tick && !busy) begin // R22
					if (s.dcnt <= 14'h0001) begin
						next_s.gate_int = 1'b0; // R18
						next_s.dly = trig_pkg::DLY_IDLE;
					end else begin
						next_s.dcnt = 14'(s.dcnt - 1'b1);
					end
				end
			end
			default: begin
				next_s.dly = trig_pkg::DLY_IDLE;
			end
		endcase
		if (rst_on && !normal) begin
			next_s.dly = trig_pkg::DLY_IDLE; // R07
			next_s.gate_int = 1'b0;
		end
		next_s.gate_int_d = s.gate_int;

		// Samples keep arriving through errors; each mode decides what to keep
		if (sample_valid && allow) begin
			next_s.live = sample_value; // R03
		end

		case (cfg.mode)
			trig_pkg::MODE_NORMAL: begin
				if (sample_valid && allow) begin
					next_s.has_data = 1'b1; // R01
					if (!scale_error) begin
						next_s.mm_valid = 1'b1;
						if (!s.mm_valid || sample_value > s.mx) begin
							next_s.mx = sample_value;
						end
						if (!s.mm_valid || sample_value < s.mn) begin
							next_s.mn = sample_value;
						end
					end
				end
			end
			trig_pkg::MODE_SAMPLE: begin
				if (grise && allow && !scale_error && !hold_on) begin // R05
					next_s.res = s.live; // R04
					next_s.has_data = 1'b1;
					next_s.pulse = 1'b1; // R13
					next_s.mm_valid = 1'b1;
					if (!s.mm_valid || s.live > s.mx) begin
						next_s.mx = s.live; // R16
					end
					if (!s.mm_valid || s.live < s.mn) begin
						next_s.mn = s.live; // R16
					end
				end
			end
			trig_pkg::MODE_PEAK, trig_pkg::MODE_VALLEY, trig_pkg::MODE_PP: begin
				if (grise) begin
					next_s.pseen = 1'b0;
					next_s.perr = 1'b0;
				end else if (s.gate_int && allow && !hold_on) begin
					if (scale_error) begin
						next_s.perr = 1'b1; // R06
					end else if (sample_valid && !s.perr) begin
						next_s.pseen = 1'b1;
						if (!s.pseen || sample_value > s.pmx) begin
							next_s.pmx = sample_value; // R08 R10
						end
						if (!s.pseen || sample_value < s.pmn) begin
							next_s.pmn = sample_value; // R09 R10
						end
					end
				end
				if (gfall && s.pseen && !s.perr && allow) begin // R06
					case (cfg.mode)
						trig_pkg::MODE_PEAK: next_s.res = s.pmx; // R08
						trig_pkg::MODE_VALLEY: next_s.res = s.pmn; // R09
						default: next_s.res = W'(s.pmx - s.pmn); // R10
					endcase
					next_s.has_data = 1'b1;
					next_s.pulse = 1'b1; // R13
					next_s.mx = s.pmx; // R17
					next_s.mn = s.pmn; // R17
					next_s.mm_valid = 1'b1;
				end
			end
			default: begin
			end
		endcase

		// Panel clear obeys the lockout; the reset pin overrides it below
		if (cfg.clear_mm && !cfg.lockout) begin
			next_s.mm_valid = 1'b0;
			next_s.mx = '0;
			next_s.mn = '0;
		end
		if (rst_on) begin
			next_s.has_data = 1'b0; // R07
			next_s.res = '0;
			next_s.live = '0;
			next_s.pseen = 1'b0;
			next_s.pulse = 1'b0;
			next_s.mm_valid = 1'b0; // R14
			next_s.mx = '0;
			next_s.mn = '0;
		end

		next_s.hold_d = hold_on;
		if (hold_on && !s.hold_d) begin
			next_s.held = normal ? s.live : s.disp; // R02
		end
		if (hold_on) begin
			dv = next_s.held; // R02 R03
		end else if (normal) begin
			dv = next_s.live;
		end else begin
			dv = next_s.res;
		end
		next_s.disp = next_s.has_data ? dv : '0;
		next_s.analog = next_s.has_data ? dv : '0; // R11
		next_s.derr = scale_error; // R03

		// Max and min stay hidden until something was measured
		next_s.refused = cfg.view != 2'h0 && !(next_s.has_data && next_s.mm_valid); // R15
		if (cfg.view[0] && !next_s.refused) begin
			next_s.panel = next_s.mx;
		end else if (cfg.view[1] && !next_s.refused) begin
			next_s.panel = next_s.mn;
		end else begin
			next_s.panel = next_s.disp;
		end

		next_s.ind = gate_on; // R01
		next_s.meas = allow && (normal || s.gate_int);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= ST_RESET;
		end else if (ce) begin
			s <= next_s;
		end
	end
endmodule // event_trigger_hold_control

/* trig_pkg.sv */
// Shared constants, register map and types for the event trigger controller
package trig_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int TICK_PERIOD_MS = 100;
	localparam int TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int DATA_W = 20;
	localparam int DLY_W = 14;
	localparam int ST_W = 10;
	localparam logic [13:0] DELAY_MAX = 14'h270f;
	localparam logic [9:0] STARTUP_MAX = 10'h3e7;
	localparam logic [13:0] DELAY_RESET = 14'h0000;
	localparam logic [9:0] STARTUP_RESET = 10'h000;
	typedef enum logic [2:0] {
		MODE_NORMAL = 3'h0,
		MODE_SAMPLE = 3'h1,
		MODE_PEAK = 3'h2,
		MODE_VALLEY = 3'h3,
		MODE_PP = 3'h4
	} mode_t;
	localparam mode_t MODE_RESET = MODE_NORMAL;
	typedef enum logic [2:0] {
		DLY_IDLE = 3'b001,
		DLY_ON = 3'b010,
		DLY_OFF = 3'b100
	} dly_t;
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_ON_DLY = 8'h04;
	localparam logic [7:0] OFS_OFF_DLY = 8'h08;
	localparam logic [7:0] OFS_STARTUP = 8'h0c;
	localparam logic [7:0] OFS_VIEW = 8'h10;
	localparam logic [7:0] OFS_CLEAR = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_DISPLAY = 8'h1c;
	localparam logic [7:0] OFS_MAX = 8'h20;
	localparam logic [7:0] OFS_MIN = 8'h24;
	localparam int MODE_LOCK_BIT = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* cfg_if.sv */
// Configuration and status carrier between register slave and trigger core
`timescale 1ns/1ps
interface cfg_if #(parameter int W = trig_pkg::DATA_W);
	trig_pkg::mode_t mode;
	logic lockout;
	logic [13:0] on_ticks;
	logic [13:0] off_ticks;
	logic [9:0] st_ticks;
	logic [1:0] view;
	logic clear_mm;
	logic [6:0] status;
	logic signed [W-1:0] display;
	logic signed [W-1:0] max_val;
	logic signed [W-1:0] min_val;
	modport regs(output mode, lockout, on_ticks, off_ticks, st_ticks, view, clear_mm,
		input status, display, max_val, min_val);
	modport core(input mode, lockout, on_ticks, off_ticks, st_ticks, view, clear_mm,
		output status, display, max_val, min_val);
endinterface

/* axil_regs.sv */
// AXI4-Lite register slave holding the trigger settings
`timescale 1ns/1ps
module axil_regs (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	cfg_if.regs cfg
);
	typedef struct packed {
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		trig_pkg::mode_t mode;
		logic lockout;
		logic [13:0] on_ticks;
		logic [13:0] off_ticks;
		logic [9:0] st_ticks;
		logic [1:0] view;
		logic clear_mm;
	} regs_t;
	localparam regs_t REGS_RESET = '{mode: trig_pkg::MODE_RESET, on_ticks: trig_pkg::DELAY_RESET,
		off_ticks: trig_pkg::DELAY_RESET, st_ticks: trig_pkg::STARTUP_RESET, default: '0};
	regs_t s;
	regs_t next_s;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	assign awready = !s.aw_got && !s.bvalid;
	assign wready = !s.w_got && !s.bvalid;
	assign arready = !s.rvalid;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign cfg.mode = s.mode;
	assign cfg.lockout = s.lockout;
	assign cfg.on_ticks = s.on_ticks;
	assign cfg.off_ticks = s.off_ticks;
	assign cfg.st_ticks = s.st_ticks;
	assign cfg.view = s.view;
	assign cfg.clear_mm = s.clear_mm;

	always_comb begin
		logic [31:0] wd;
		wd = '0;
		next_s = s;
		next_s.clear_mm = 1'b0;
		if (awvalid && awready) begin
			next_s.aw_got = 1'b1;
			next_s.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			next_s.w_got = 1'b1;
			next_s.w_data = wdata;
			next_s.w_strb = wstrb;
		end
		if (s.aw_got && s.w_got && !s.bvalid) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = trig_pkg::RESP_OKAY;
			case (s.aw_addr)
				trig_pkg::OFS_MODE: begin
					wd = merge({23'h0, s.lockout, 5'h00, s.mode}, s.w_data, s.w_strb);
					// Undefined mode codes are dropped so the core never sees one
					if (wd[2:0] <= trig_pkg::MODE_PP) begin
						next_s.mode = trig_pkg::mode_t'(wd[2:0]); // R26
					end
					next_s.lockout = wd[trig_pkg::MODE_LOCK_BIT];
				end
				trig_pkg::OFS_ON_DLY: begin
					wd = merge({18'h0, s.on_ticks}, s.w_data, s.w_strb);
					if (wd[31:0] <= {18'h0, trig_pkg::DELAY_MAX}) begin
						next_s.on_ticks = wd[13:0]; // R18
					end
				end
				trig_pkg::OFS_OFF_DLY: begin
					wd = merge({18'h0, s.off_ticks}, s.w_data, s.w_strb);
					if (wd[31:0] <= {18'h0, trig_pkg::DELAY_MAX}) begin
						next_s.off_ticks = wd[13:0]; // R18
					end
				end
				trig_pkg::OFS_STARTUP: begin
					wd = merge({22'h0, s.st_ticks}, s.w_data, s.w_strb);
					if (wd[31:0] <= {22'h0, trig_pkg::STARTUP_MAX}) begin
						next_s.st_ticks = wd[9:0]; // R22
					end
				end
				trig_pkg::OFS_VIEW: begin
					wd = merge({30'h0, s.view}, s.w_data, s.w_strb);
					next_s.view = wd[1:0];
				end
				trig_pkg::OFS_CLEAR: begin
					next_s.clear_mm = s.w_strb[0] && s.w_data[0];
				end
				trig_pkg::OFS_STATUS, trig_pkg::OFS_DISPLAY, trig_pkg::OFS_MAX, trig_pkg::OFS_MIN: begin
				end
				default: begin
					next_s.bresp = trig_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
		if (arvalid && !s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = trig_pkg::RESP_OKAY;
			case (araddr)
				trig_pkg::OFS_MODE: next_s.rdata = {23'h0, s.lockout, 5'h00, s.mode};
				trig_pkg::OFS_ON_DLY: next_s.rdata = {18'h0, s.on_ticks};
				trig_pkg::OFS_OFF_DLY: next_s.rdata = {18'h0, s.off_ticks};
				trig_pkg::OFS_STARTUP: next_s.rdata = {22'h0, s.st_ticks};
				trig_pkg::OFS_VIEW: next_s.rdata = {30'h0, s.view};
				trig_pkg::OFS_CLEAR: next_s.rdata = 32'h0000_0000;
				trig_pkg::OFS_STATUS: next_s.rdata = {25'h0, cfg.status};
				trig_pkg::OFS_DISPLAY: next_s.rdata = 32'(cfg.display);
				trig_pkg::OFS_MAX: next_s.rdata = 32'(cfg.max_val);
				trig_pkg::OFS_MIN: next_s.rdata = 32'(cfg.min_val);
				default: begin
					next_s.rdata = 32'h0000_0000;
					next_s.rresp = trig_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= REGS_RESET;
		end else if (ce) begin
			s <= next_s;
		end
	end
endmodule // axil_regs

/* trig_checker.sv */
// Port-level assertions for the event trigger controller
`timescale 1ns/1ps
module trig_checker #(
	parameter int W = trig_pkg::DATA_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic gate_n,
	input wire logic hold_n,
	input wire logic trig_reset_n,
	input wire logic scale_error,
	input wire logic signed [W-1:0] display_value,
	input wire logic display_error,
	input wire logic signed [W-1:0] analog_level,
	input wire logic gate_active_indicator,
	input wire logic one_shot,
	input wire logic measuring
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Two synchroniser stages and one output register
	a_indicator_delay: assert property (gate_active_indicator == !$past(gate_n, 3))
		else $error("gate indicator out of step with pin");
	a_analog_follows: assert property (analog_level == display_value)
		else $error("analog level differs from display");
	a_reset_clears: assert property (!trig_reset_n [*5] |-> display_value == 0 && analog_level == 0)
		else $error("display not cleared under reset pin");
	a_reset_idle: assert property (!trig_reset_n [*5] |-> !measuring && !one_shot)
		else $error("measuring under reset pin");
	a_hold_freeze: assert property ((!hold_n && trig_reset_n) [*5] |-> $stable(display_value))
		else $error("display moved while held");
	a_shot_single: assert property (one_shot |=> !one_shot)
		else $error("one-shot longer than a cycle");
	a_error_shown: assert property (display_error == $past(scale_error))
		else $error("error flag not mirrored");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read not answered next cycle");
	cover property (one_shot && !gate_active_indicator);
	cover property (!hold_n [*5]);
	cover property (rvalid && !arready);
endmodule // trig_checker

bind event_trigger_hold_control trig_checker #(.W(W)) chk (.aclk, .aresetn, .arvalid, .arready, .rvalid,
	.gate_n, .hold_n, .trig_reset_n, .scale_error, .display_value, .display_error, .analog_level,
	.gate_active_indicator, .one_shot, .measuring);

/* trig_contacts.sv */
// Contact bank standing in for the external trigger source
`timescale 1ns/1ps
module trig_contacts (
	input wire logic aclk,
	input wire logic [3:0] closed,
	output logic gate_n,
	output logic hold_n,
	output logic trig_reset_n,
	output logic startup_inhibit_input_n
);
	// Pull-ups keep open contacts high; a closed contact pulls its line low
	initial {startup_inhibit_input_n, trig_reset_n, hold_n, gate_n} = 4'hf;
	always @(posedge aclk) begin
		{startup_inhibit_input_n, trig_reset_n, hold_n, gate_n} <= ~closed;
	end
endmodule // trig_contacts

/* tb_top.sv */
// Self-checking bench for the event trigger controller
`timescale 1ns/1ps
module tb_top;
	localparam int W = trig_pkg::DATA_W;
	logic aclk = 0, aresetn = 0, ce = 1;
	logic [7:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 4'hf, closed = 0;
	logic sample_valid = 0, scale_error = 0;
	logic signed [W-1:0] sample_value = 0;
	logic awready, wready, bvalid, arready, rvalid, display_error, gate_active_indicator, one_shot, measuring;
	logic gate_n, hold_n, trig_reset_n, startup_inhibit_input_n;
	logic [1:0] rresp;
	logic [31:0] rdata;
	logic signed [W-1:0] display_value, analog_level, panel_value;
	logic [33:0] q[$];
	int n_mismatch = 0, n_compared = 0, mx, mn, v, seed = 32'hb44b69d4;

	always #50 aclk = ~aclk;

	event_trigger_hold_control #(.W(W), .TICK_CYCLES(10)) dut (.aclk, .aresetn, .ce, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp(), .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .gate_n, .hold_n, .trig_reset_n, .startup_inhibit_input_n,
		.sample_valid, .sample_value, .scale_error, .display_value, .display_error, .analog_level,
		.panel_value, .gate_active_indicator, .one_shot, .measuring);
	trig_contacts pc (.aclk, .closed, .gate_n, .hold_n, .trig_reset_n, .startup_inhibit_input_n);

	task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 0;
			if (wready)
				wvalid <= 0;
		end while (!bvalid);
		bready <= 0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] x);
		q.push_back(x);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 0;
		end while (!rvalid);
		rready <= 0;
	endtask

	task automatic feed(input int s);
		@(posedge aclk);
		sample_valid <= 1;
		sample_value <= W'(s);
		@(posedge aclk);
		sample_valid <= 0;
	endtask

	task automatic gate_pulse;
		@(posedge aclk);
		closed[0] <= 1;
		@(posedge aclk);
		closed[0] <= 0;
		cyc(10);
	endtask

	// Results land at settled values; only read answers and pulses with the gate indicator off count as results
	always @(negedge aclk) begin
		if (aresetn && (one_shot && !gate_active_indicator || rvalid && rready)) begin
			if (q.size() == 0)
				check("unsolicited result", 34'h1, 34'h0);
			else
				check("result", rvalid ? {rresp, rdata} : {2'h0, 32'(display_value)}, q.pop_front());
		end
	end

	initial begin
		cyc(6);
		aresetn <= 1;
		rd(trig_pkg::OFS_MODE, 0);
		rd(trig_pkg::OFS_ON_DLY, 0);
		rd(8'h30, {trig_pkg::RESP_SLVERR, 32'h0});
		wr(trig_pkg::OFS_MODE, 32'h5, 4'hf);
		rd(trig_pkg::OFS_MODE, 0);
		wr(trig_pkg::OFS_MODE, 32'h102, 4'h1);
		rd(trig_pkg::OFS_MODE, 2);
		wr(trig_pkg::OFS_MODE, 1, 4'hf);
		repeat (2) begin
			v = $random(seed) % 1000;
			repeat (2) feed(v);
			q.push_back({2'h0, 32'(v)});
			gate_pulse;
		end
		// Gate edges under a scaling error or a hold must not measure
		scale_error <= 1;
		feed(7);
		gate_pulse;
		scale_error <= 0;
		closed[1] <= 1;
		cyc(4);
		gate_pulse;
		closed[1] <= 0;
		// Two-tick gate delays from here on, so the internal gate lags the pin both ways
		wr(trig_pkg::OFS_ON_DLY, 2, 4'hf);
		wr(trig_pkg::OFS_OFF_DLY, 2, 4'hf);
		for (int m = 2; m < 5; m++) begin
			wr(trig_pkg::OFS_MODE, m, 4'hf);
			mx = -1000;
			mn = 1000;
			closed[0] <= 1;
			cyc(8);
			check("measuring", measuring, 0);
			cyc(25);
			check("measuring", measuring, 1);
			repeat (5) begin
				v = $random(seed) % 1000;
				feed(v);
				if (v > mx)
					mx = v;
				if (v < mn)
					mn = v;
			end
			cyc(2);
			q.push_back({2'h0, 32'(m == 2 ? mx : m == 3 ? mn : mx - mn)});
			closed[0] <= 0;
			cyc(8);
			check("measuring", measuring, 1);
			cyc(22);
		end
		wr(trig_pkg::OFS_MODE, 32'h104, 4'hf);
		wr(trig_pkg::OFS_VIEW, 1, 4'hf);
		closed[2] <= 1;
		cyc(8);
		rd(trig_pkg::OFS_DISPLAY, 0);
		rd(trig_pkg::OFS_MAX, 0);
		rd(trig_pkg::OFS_STATUS, 32'h30);
		closed[2] <= 0;
		cyc(6);
		wr(trig_pkg::OFS_STARTUP, 2, 4'hf);
		wr(trig_pkg::OFS_MODE, 0, 4'hf);
		gate_pulse;
		closed[3] <= 1;
		cyc(6);
		check("measuring", measuring, 0);
		closed[3] <= 0;
		cyc(30);
		check("measuring", measuring, 1);
		cyc(10);
		// Data exists again, so the max request set earlier is honoured
		v = $random(seed) % 1000;
		feed(v);
		cyc(1);
		check("panel", panel_value, v);
		tally_and_finish;
	end

	// About ten times the expected run length
	initial begin
		#500000;
		n_mismatch++;
		tally_and_finish;
	end
endmodule // tb_top
